// ### rtl/serial_unit.sv
/*
 Serial transmitter and receiver with wakeup, behind an AHB-Lite slave.
 Assumes a single AHB-Lite master and an asynchronous receive pin.
*/
module serial_unit
    import serial_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rxd,
    output logic             txd_out,
    output logic             txd_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Sample rate divider
    logic [7:0] samp_cnt;
    logic       samp_tick;
    wire        samp_last = samp_cnt == SAMP_LAST;

    always_ff @(posedge mclk) begin
        if (rst) begin
            samp_cnt  <= 8'h00;
            samp_tick <= 1'h0;
        end else begin
            samp_cnt  <= samp_last ? 8'h00 : samp_cnt + 8'h01;
            samp_tick <= samp_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic       m;
    logic       wake;
    logic       t8;
    logic       te;
    logic       re;
    logic       receiver_sleep_bit;
    logic       sbk;
    logic       tdre;
    logic       tc;
    logic       receive_full_flag;
    logic       idle;
    logic       ovr;
    logic       nf;
    logic       fe;
    logic [8:0] rx_buf;
    logic [7:0] tx_buf;
    logic [4:0] rx_arm;
    logic       tx_arm;
    logic       wr_pend;
    logic [7:0] wr_idx;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite decode
    wire       acc     = hsel && hready && htrans[1];
    wire [7:0] a_idx   = haddr[9:2];
    wire       rd_stat = acc && !hwrite && a_idx == IDX_STAT;
    wire       rd_data = acc && !hwrite && a_idx == IDX_DATA;
    wire       wr_c1   = wr_pend && wr_idx == IDX_CTL1;
    wire       wr_c2   = wr_pend && wr_idx == IDX_CTL2;
    wire       wr_data = wr_pend && wr_idx == IDX_DATA;

    wire [7:0] c1_val = {rx_buf[8], t8, 1'h0, m, wake, 3'h0};
    wire [7:0] c2_val = {4'h0, te, re, receiver_sleep_bit, sbk};
    wire [4:0] rx_flg = {receive_full_flag, idle, ovr, nf, fe};
    wire [7:0] st_val = {tdre, tc, rx_flg, 1'h0};
    wire [7:0] rd_val = (a_idx == IDX_DATA) ? rx_buf[7:0] :
                        (a_idx == IDX_CTL1) ? c1_val :
                        (a_idx == IDX_CTL2) ? c2_val :
                        (a_idx == IDX_STAT) ? st_val : 8'h00;

    wire [4:0] rx_clr   = rd_data ? rx_arm : 5'h00;
    wire       tdre_clr = wr_data && tx_arm;

    always_ff @(posedge mclk) begin
        if (rst) begin
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'h0;
            wr_idx    <= 8'h00;
        end else begin
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
            wr_pend   <= acc && hwrite;
            if (acc) wr_idx <= a_idx;
            if (acc && !hwrite) hrdata <= {24'h00_0000, rd_val};
        end
    end

    // Status read arms the clear; data access completes it
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_arm <= 5'h00;
            tx_arm <= 1'h0;
        end else begin
            if (rd_stat) rx_arm <= rx_flg;
            else if (rd_data) rx_arm <= 5'h00;
            if (rd_stat) tx_arm <= tdre;
            else if (wr_data) tx_arm <= 1'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            m      <= 1'h0;
            wake   <= 1'h0;
            t8     <= 1'h0;
            te     <= 1'h0;
            re     <= 1'h0;
            sbk    <= 1'h0;
            tx_buf <= 8'h00;
        end else begin
            if (wr_c1) begin
                t8   <= hwdata[CTL1_T8];
                m    <= hwdata[CTL1_M];
                wake <= hwdata[CTL1_WAKE];
            end
            if (wr_c2) begin
                te  <= hwdata[CTL2_TE];
                re  <= hwdata[CTL2_RE];
                sbk <= hwdata[CTL2_SBK];
            end
            if (wr_data) tx_buf <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    tx_state_t   tx_state;
    logic [10:0] tx_shift;
    logic [3:0]  tx_left;
    logic [3:0]  tx_phase;
    logic        pre_pend;
    logic        te_q;

    wire [3:0]  flen     = m ? FRAME_NINE : FRAME_EIGHT;
    wire        bit_tick = samp_tick && tx_phase == PHASE_LAST;
    wire        tx_busy  = tx_state == TX_SEND;
    wire        tx_free  = !tx_busy || tx_left == 4'h1;
    wire        tx_go    = bit_tick && tx_free && te;
    wire        ld_pre   = tx_go && pre_pend;
    wire        ld_brk   = tx_go && !pre_pend && sbk;
    wire        ld_dat   = tx_go && !pre_pend && !sbk && !tdre;
    wire        ld_any   = ld_pre || ld_brk || ld_dat;
    wire [10:0] dat_frm  = m ? {1'h1, t8, tx_buf, 1'h0}
                             : {2'h3, tx_buf, 1'h0};

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_shift <= FRAME_ONES;
            tx_left  <= 4'h0;
            tx_phase <= 4'h0;
        end else begin
            if (samp_tick) tx_phase <= tx_phase + 4'h1;
            if (ld_any) begin
                tx_state <= TX_SEND;
                tx_left  <= flen;
                tx_shift <= ld_dat ? dat_frm :
                            ld_brk ? FRAME_ZEROS :
                            FRAME_ONES;
            end else if (bit_tick && tx_free) begin
                tx_state <= TX_IDLE;
                tx_shift <= FRAME_ONES;
            end else if (bit_tick) begin
                tx_shift <= {1'h1, tx_shift[10:1]};
                tx_left  <= tx_left - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            txd_out  <= 1'h1;
            txd_oe   <= 1'h0;
            te_q     <= 1'h0;
            pre_pend <= 1'h0;
            tdre     <= 1'h1;
            tc       <= 1'h1;
        end else begin
            txd_out <= tx_shift[0];
            txd_oe  <= te || tx_busy;
            te_q    <= te;
            if (te && !te_q) pre_pend <= 1'h1;
            else if (ld_pre) pre_pend <= 1'h0;
            if (ld_dat) tdre <= 1'h1;
            else if (tdre_clr) tdre <= 1'h0;
            tc <= !tx_busy && !ld_any && tdre && !pre_pend && !sbk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    logic       rx_meta;
    logic       rx_line;
    rx_state_t  rx_state;
    logic [3:0] bit_idx;
    logic [8:0] rx_shift;
    logic       noise_acc;
    logic       v_val;
    logic       v_noise;
    logic       v_ready;
    logic       v_end;
    logic [7:0] idle_cnt;
    logic       line_act;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_meta <= 1'h1;
            rx_line <= 1'h1;
        end else begin
            rx_meta <= rxd;
            rx_line <= rx_meta;
        end
    end

    wire       in_frame = rx_state == RX_FRAME;
    wire       rx_start = rx_state == RX_IDLE && re && samp_tick && !rx_line;
    wire [3:0] msb_idx  = m ? MSB_NINE : MSB_EIGHT;
    wire [3:0] stop_idx = flen - 4'h1;
    wire       f_start  = in_frame && v_ready && bit_idx == 4'h0 && v_val;
    wire       rx_done  = in_frame && v_ready && bit_idx == stop_idx;
    wire       amark    = in_frame && v_ready && bit_idx == msb_idx &&
                          v_val && wake && receiver_sleep_bit;
    wire       stop_ok  = v_val;
    wire       f_noise  = noise_acc || v_noise;
    wire       rx_live  = rx_done && !receiver_sleep_bit;
    wire       set_or   = rx_live && receive_full_flag;
    wire       rx_load  = rx_live && !receive_full_flag && !fe;
    wire [7:0] idle_end = {flen, 4'h0};
    wire       idle_evt = samp_tick && rx_line && line_act &&
                          idle_cnt == idle_end - 8'h01;
    wire       wake_evt = amark || (idle_evt && !wake && receiver_sleep_bit);

    bit_vote voter (
        .mclk      (mclk),
        .rst       (rst),
        .tick      (samp_tick),
        .restart   (rx_start),
        .line      (rx_line),
        .bit_val   (v_val),
        .bit_noise (v_noise),
        .bit_ready (v_ready),
        .slot_end  (v_end)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_state  <= RX_IDLE;
            bit_idx   <= 4'h0;
            rx_shift  <= 9'h000;
            noise_acc <= 1'h0;
        end else begin
            unique case (rx_state)
                RX_IDLE: begin
                    if (rx_start) begin
                        rx_state  <= RX_FRAME;
                        bit_idx   <= 4'h0;
                        noise_acc <= 1'h0;
                    end
                end
                RX_FRAME: begin
                    if (f_start) begin
                        rx_state <= RX_IDLE;
                    end else if (rx_done) begin
                        rx_state <= stop_ok ? RX_IDLE : RX_HOLD;
                    end else begin
                        if (v_ready) begin
                            noise_acc <= f_noise;
                            if (bit_idx != 4'h0)
                                rx_shift[bit_idx - 4'h1] <= v_val;
                        end
                        if (v_end) bit_idx <= bit_idx + 4'h1;
                    end
                end
                RX_HOLD: begin
                    if (rx_line) rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Idle line: one full frame time of high after activity
    always_ff @(posedge mclk) begin
        if (rst) begin
            idle_cnt <= 8'h00;
            line_act <= 1'h0;
        end else if (!rx_line) begin
            idle_cnt <= 8'h00;
            line_act <= 1'h1;
        end else if (samp_tick) begin
            if (idle_evt) line_act <= 1'h0;
            if (idle_cnt != idle_end) idle_cnt <= idle_cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) receiver_sleep_bit <= 1'h0;
        else if (wr_c2) receiver_sleep_bit <= hwdata[CTL2_RWU];
        else if (wake_evt) receiver_sleep_bit <= 1'h0;
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_buf <= 9'h000;
            receive_full_flag   <= 1'h0;
            idle   <= 1'h0;
            ovr    <= 1'h0;
            nf     <= 1'h0;
            fe     <= 1'h0;
        end else begin
            if (rx_load) rx_buf <= {m & rx_shift[8], rx_shift[7:0]};
            receive_full_flag <= rx_load | (receive_full_flag & !rx_clr[4]);
            idle <= (idle_evt & !receiver_sleep_bit) | (idle & !rx_clr[3]);
            ovr  <= set_or | (ovr & !rx_clr[2]);
            nf   <= (rx_load & f_noise) | (nf & !rx_clr[1]);
            fe   <= (rx_load & !stop_ok) | (fe & !rx_clr[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_start_low: assert property (
        @(posedge mclk) disable iff (rst) ld_dat |=> ##1 !txd_out)
        else $error("start bit not low on pin");

    chk_tx_drive: assert property (
        @(posedge mclk) disable iff (rst)
        (!te && !tx_busy) ##1 (!te && !tx_busy) |=> !txd_oe)
        else $error("pin driven while transmitter off");

    chk_buffer_freed: assert property (
        @(posedge mclk) disable iff (rst) ld_dat |=> tdre && tx_busy)
        else $error("buffer not freed on shifter load");

    chk_preamble_queued: assert property (
        @(posedge mclk) disable iff (rst) $rose(te) |=> pre_pend)
        else $error("no preamble after enable");

    chk_sleep_mute: assert property (
        @(posedge mclk) disable iff (rst) $rose(receive_full_flag) |-> !$past(receiver_sleep_bit))
        else $error("receive full set while asleep");

    chk_overrun_keep: assert property (
        @(posedge mclk) disable iff (rst)
        set_or |=> ovr && receive_full_flag && $stable(rx_buf) && !$rose(fe))
        else $error("overrun disturbed buffer");

    chk_fe_with_receive_full_flag: assert property (
        @(posedge mclk) disable iff (rst) $rose(fe) |-> $rose(receive_full_flag))
        else $error("framing flag without receive full");

    chk_nf_with_receive_full_flag: assert property (
        @(posedge mclk) disable iff (rst) $rose(nf) |-> $rose(receive_full_flag))
        else $error("noise flag without receive full");

    chk_fe_blocks: assert property (
        @(posedge mclk) disable iff (rst) fe |=> $stable(rx_buf))
        else $error("transfer while framing flag set");

    chk_rx_transfer: assert property (
        @(posedge mclk) disable iff (rst)
        rx_load |=> receive_full_flag && rx_buf[7:0] == $past(rx_shift[7:0]))
        else $error("character not moved whole");

    chk_amark_wake: assert property (
        @(posedge mclk) disable iff (rst)
        amark && !wr_c2 |=> !receiver_sleep_bit ##[1:1000] rx_live)
        else $error("address mark did not wake");

    chk_idle_wake: assert property (
        @(posedge mclk) disable iff (rst)
        idle_evt && receiver_sleep_bit && !wake && !wr_c2 |=> !receiver_sleep_bit && !$rose(idle))
        else $error("idle line did not wake");
endmodule

// ### shared/serial_pkg.sv
/*
 Constants, register map and state types of the serial unit.
 Assumes one 100 MHz clock and a fixed 16x sample rate.
*/
package serial_pkg;
    localparam int CLK_HZ     = 100000000;
    localparam int BAUD_BPS   = 115200;
    localparam int OVERSAMPLE = 16;
    localparam int SAMPLE_DIV = CLK_HZ / (BAUD_BPS * OVERSAMPLE);
    localparam logic [7:0] SAMP_LAST = 8'(SAMPLE_DIV - 1);

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTL1 = 8'h2C;
    localparam logic [7:0] IDX_CTL2 = 8'h2D;
    localparam logic [7:0] IDX_STAT = 8'h2E;
    localparam logic [7:0] IDX_DATA = 8'h2F;

    localparam int CTL1_T8   = 6;
    localparam int CTL1_M    = 4;
    localparam int CTL1_WAKE = 3;
    localparam int CTL2_TE   = 3;
    localparam int CTL2_RE   = 2;
    localparam int CTL2_RWU  = 1;
    localparam int CTL2_SBK  = 0;

    localparam logic [10:0] FRAME_ONES  = 11'h7FF;
    localparam logic [10:0] FRAME_ZEROS = 11'h000;
    localparam logic [3:0]  FRAME_EIGHT = 4'hA;
    localparam logic [3:0]  FRAME_NINE  = 4'hB;
    localparam logic [3:0]  MSB_EIGHT   = 4'h8;
    localparam logic [3:0]  MSB_NINE    = 4'h9;

    localparam logic [3:0] VOTE_A     = 4'h7;
    localparam logic [3:0] VOTE_B     = 4'h8;
    localparam logic [3:0] VOTE_C     = 4'h9;
    localparam logic [3:0] PHASE_LAST = 4'hF;

    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_HOLD} rx_state_t;
endpackage

// ### rtl/bit_vote.sv
/*
 Three-sample majority voter for one receive bit slot.
 Assumes a 16x sample tick and a synchronised line.
*/
module bit_vote
    import serial_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic tick,
    input  wire logic restart,
    input  wire logic line,
    output logic      bit_val,
    output logic      bit_noise,
    output logic      bit_ready,
    output logic      slot_end
);
    logic [3:0] phase;
    logic [1:0] samp;

    wire maj   = (samp[0] & samp[1]) | (samp[0] & line) | (samp[1] & line);
    wire mixed = (samp[0] | samp[1] | line) & ~(samp[0] & samp[1] & line);

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase     <= 4'h0;
            samp      <= 2'h0;
            bit_val   <= 1'h1;
            bit_noise <= 1'h0;
            bit_ready <= 1'h0;
            slot_end  <= 1'h0;
        end else begin
            bit_ready <= 1'h0;
            slot_end  <= 1'h0;
            if (restart) begin
                phase <= 4'h1;
            end else if (tick) begin
                phase <= phase + 4'h1;
                if (phase == VOTE_A) samp[0] <= line;
                if (phase == VOTE_B) samp[1] <= line;
                if (phase == VOTE_C) begin
                    bit_val   <= maj;
                    bit_noise <= mixed;
                    bit_ready <= 1'h1;
                end
                if (phase == PHASE_LAST) slot_end <= 1'h1;
            end
        end
    end
endmodule

// ### testbench/remote_node.sv
/*
 Remote serial node on the far side of the line: sends frames on
 request and decodes every frame that arrives from the unit.
 Assumes the shared package bit timing and an idle-high line.
*/
module remote_node
    import serial_pkg::*;
(
    input  wire logic mclk,
    input  wire logic line_in,
    input  wire logic nine_bits,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BIT = OVERSAMPLE * SAMPLE_DIV;

    logic [9:0] seen;
    logic [9:0] rx_q[$];
    int         k;

    initial line_out = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Sender; back-to-back calls leave no gap
    task automatic send_frame(input logic [8:0] d, input logic nine,
                              input logic stop);
        line_out <= 1'b0;
        repeat (BIT) @(posedge mclk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            line_out <= d[i];
            repeat (BIT) @(posedge mclk);
        end
        line_out <= stop;
        repeat (BIT) @(posedge mclk);
        if (!stop) line_out <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Receiver; samples mid-bit, queues {stop, data}
    always begin
        @(posedge mclk);
        if (line_in === 1'b0) begin
            seen = '0;
            repeat (BIT / 2) @(posedge mclk);
            for (k = 0; k < (nine_bits ? 9 : 8); k++) begin
                repeat (BIT) @(posedge mclk);
                seen[k] = line_in;
            end
            repeat (BIT) @(posedge mclk);
            seen[9] = line_in;
            rx_q.push_back(seen);
        end
    end
endmodule

// ### testbench/async_serial_transceiver_wakeup_tb_top.sv
/*
 Self-checking bench: AHB-Lite register access, remote node traffic.
 Assumes the register indices and flag positions of the package.
*/
module async_serial_transceiver_wakeup_tb_top
    import serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rxd;
    logic        txd_out;
    logic        txd_oe;
    logic        line;
    logic        nine_bits;
    logic [31:0] rd;
    int          err_count;
    int          compares;

    assign hready = hreadyout;
    assign line   = txd_oe ? txd_out : 1'b1;

    always #5 mclk = ~mclk;

    serial_unit uut (
        .mclk      (mclk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rxd       (rxd),
        .txd_out   (txd_out),
        .txd_oe    (txd_oe)
    );

    remote_node partner (
        .mclk      (mclk),
        .line_in   (line),
        .nine_bits (nine_bits),
        .line_out  (rxd)
    );

    ////////////////////////////////////////////////////////////////////
    // Report and compare
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Bus master
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        hsize  <= 3'b010;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask,
                          input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(rd & mask, exp);
    endtask

    task automatic poll_tdre();
        int n;
        n = 0;
        do begin
            bus(1'b0, IDX_STAT, 32'h0000_0000);
            n++;
        end while (rd[7] !== 1'b1 && n < 10000);
        if (rd[7] !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic wait_frame(input logic [9:0] exp);
        int n;
        n = 0;
        while (partner.rx_q.size() == 0 && n < 40000) begin
            @(posedge mclk);
            n++;
        end
        if (partner.rx_q.size() == 0) begin
            err_count++;
            wrap_up();
        end
        check({22'h0, partner.rx_q.pop_front()}, {22'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        mclk      = 1'b0;
        rst       = 1'b1;
        hsel      = 1'b0;
        haddr     = 32'h0000_0000;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'b010;
        hwdata    = 32'h0000_0000;
        nine_bits = 1'b0;
        err_count = 0;
        compares  = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        check({31'h0, txd_oe}, 32'h0000_0000);
        rd_chk(IDX_STAT, 32'hFFFF_FFFF, 32'h0000_00C0);
        rd_chk(IDX_CTL1, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(IDX_CTL2, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        // Plain receive
        bus(1'b1, IDX_CTL2, 32'h0000_0004);
        partner.send_frame(9'h03C, 1'b0, 1'b1);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0020);
        rd_chk(IDX_DATA, 32'hFFFF_FFFF, 32'h0000_003C);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0000);
        // Overrun on back-to-back frames
        partner.send_frame(9'h011, 1'b0, 1'b1);
        partner.send_frame(9'h022, 1'b0, 1'b1);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0028);
        rd_chk(IDX_DATA, 32'hFFFF_FFFF, 32'h0000_0011);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0000);
        // Stop bit low
        partner.send_frame(9'h055, 1'b0, 1'b0);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0022);
        rd_chk(IDX_DATA, 32'hFFFF_FFFF, 32'h0000_0055);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0000);
        // Address-mark wakeup
        bus(1'b1, IDX_CTL1, 32'h0000_0008);
        bus(1'b1, IDX_CTL2, 32'h0000_0006);
        partner.send_frame(9'h012, 1'b0, 1'b1);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0000);
        partner.send_frame(9'h093, 1'b0, 1'b1);
        rd_chk(IDX_STAT, 32'h0000_002E, 32'h0000_0020);
        rd_chk(IDX_CTL2, 32'h0000_00FF, 32'h0000_0004);
        rd_chk(IDX_DATA, 32'hFFFF_FFFF, 32'h0000_0093);
        // Transmit, one character waiting behind another
        bus(1'b1, IDX_CTL1, 32'h0000_0000);
        bus(1'b1, IDX_CTL2, 32'h0000_000E);
        poll_tdre();
        bus(1'b1, IDX_DATA, 32'h0000_00A5);
        check({31'h0, txd_oe}, 32'h0000_0001);
        poll_tdre();
        bus(1'b1, IDX_DATA, 32'h0000_003C);
        wait_frame(10'h2A5);
        rd_chk(IDX_CTL2, 32'h0000_00FF, 32'h0000_000C);
        rd_chk(IDX_STAT, 32'h0000_0010, 32'h0000_0000);
        wait_frame(10'h23C);
        // Nine-bit transmit
        nine_bits <= 1'b1;
        bus(1'b1, IDX_CTL1, 32'h0000_0050);
        poll_tdre();
        bus(1'b1, IDX_DATA, 32'h0000_005A);
        wait_frame(10'h35A);
        wrap_up();
    end
endmodule
